// ===== core/dccp_pkg.sv
// package: constants and carriers for the disk control cable port
package dccp_pkg;
   localparam int CLK_MHZ = 50;
   localparam int CLK_NS = 1000 / CLK_MHZ;
   // timing figures in their own units
   localparam int SEL_MAX_NS = 600;
   localparam int CLR_MIN_NS = 250;
   localparam int TZ_MAX_US = 1000;
   localparam int IDX_W_NS = 2500;
   localparam int TZ_SLOW_MS = 1500;
   // derived cycle counts (least rounds up, longest rounds down)
   localparam int SEL_CYC = SEL_MAX_NS / CLK_NS;
   localparam int CLR_CYC = (CLR_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int TZ_MAX_CYC = TZ_MAX_US * 1000 / CLK_NS;
   localparam int IDX_CYC = IDX_W_NS / CLK_NS;
   localparam int TZ_SLOW_CYC = TZ_SLOW_MS * (1_000_000 / CLK_NS);
   // bus field positions
   localparam int BUS_W = 11;
   localparam int HEAD_W = 4;
   localparam int B_WG = 0;
   localparam int B_RG = 1;
   localparam int B_FCLR = 4;
   localparam int B_MARK = 5;
   localparam int B_TZ = 6;
   // axi register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_CYL = 8'h08;
   localparam logic [7:0] A_HEAD = 8'h0C;
   localparam logic [1:0] RESP_OK = 2'b00;
   localparam logic [1:0] RESP_ERR = 2'b10;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;

   typedef struct packed {
      logic         tag_cyl;
      logic         tag_head;
      logic         tag_ctl;
      logic [10:0]  bus;
   } dccp_tagbus_s;

   typedef struct packed {
      logic index;
      logic sector;
      logic fault;
      logic seek_err;
      logic on_cyl;
      logic ready;
      logic wprot;
      logic busy;
   } dccp_status_s;
endpackage

// ===== core/dccp_pulse.sv
// pulse stretcher: fixed-width pulse on a rising edge
`timescale 1ns/1ps
`default_nettype none
module dccp_pulse
   import dccp_pkg::*;
#(
   parameter int WIDTH = 125
) (
   input  wire logic core_clk, // clock
   input  wire logic sys_rst,  // async reset
   input  wire logic trig,     // level, rising edge fires
   output var  logic pulse     // stretched pulse
);
   typedef struct packed {
      logic        last;
      logic [15:0] cnt;
      logic        pulse;
   } dccp_pst_s;
   dccp_pst_s st, next_st;
   always_comb begin
      next_st = st;
      next_st.last = trig;
      if (trig && !st.last) begin
         next_st.cnt = 16'(WIDTH);
      end else if (st.cnt != 16'h0000) begin
         next_st.cnt = st.cnt - 16'h0001;
      end
      next_st.pulse = (trig && !st.last) || (st.cnt > 16'h0001);
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign pulse = st.pulse;
endmodule
`default_nettype wire

// ===== core/dccp_sync.sv
// edge timer: counts how long a level stays high
`timescale 1ns/1ps
`default_nettype none
module dccp_sync
   import dccp_pkg::*;
(
   input  wire logic        core_clk, // clock
   input  wire logic        sys_rst,  // async reset
   input  wire logic        lvl,      // level under measure
   output var  logic [19:0] len,      // cycles high so far
   output var  logic        fall      // one cycle at falling edge
);
   typedef struct packed {
      logic        last;
      logic [19:0] len;
      logic        fall;
   } dccp_tst_s;
   dccp_tst_s st, next_st;
   always_comb begin
      next_st = st;
      next_st.last = lvl;
      next_st.fall = st.last && !lvl;
      if (lvl) begin
         if (st.len != 20'hF_FFFF) next_st.len = st.len + 20'h0_0001;
      end else if (next_st.fall == 1'b0) begin
         next_st.len = '0;
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign len = st.len;
   assign fall = st.fall;
endmodule
`default_nettype wire

// ===== core/dccp_top.sv
// drive-side control cable port with axi4-lite register access
// Overview of operation
// - drive selects itself within 600 ns of select strobe when number matches.
// - four unit lines compared against a switch number 0 to 15.
// - eleven-bit bus meaning set by one of three tag strobes.
// - cylinder tag loads an absolute target cylinder from bits 0 to 10.
// - head tag loads head number from bits 0 to 3 only.
// - control bit 0 enables write driver while set.
// - control bit 1 enables read data; its rising edge starts sync.
// - offset plus and minus bits are ignored; on-cylinder stays.
// - fault clear pulse of 250 ns clears fault latch if cause gone.
// - mark search enable bit has no function.
// - track zero pulse 250 ns to 1 ms seeks zero and clears seek error.
// - track zero seek may take up to 1.5 seconds.
// - strobe early, strobe late and release bits are no-ops.
// - no dual-channel reservation; release is unused.
// - open cable disables the whole control interface.
// - tags, bus and status lines active only while selected.
// - one index pulse per revolution, about 2.5 us, marks sector zero.
// - sector pulses come from servo; count fixed, timing kept in seeks.
// - on-cylinder drops on seek command, returns when seek completes.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module dccp_top
   import dccp_pkg::*;
#(
   parameter int SEEK_CYC  = 1000,          // ordinary seek time limit
   parameter int SLOW_CYC  = TZ_SLOW_CYC,   // lost-position track zero seek
   parameter int MAX_CYL   = 1068           // highest cylinder
) (
   input  wire logic         core_clk,      // 50 MHz clock
   input  wire logic         sys_rst,       // async reset, high
   input  wire logic         sel_tag,       // unit selection strobe
   input  wire logic [3:0]   unit_num,      // unit number lines
   input  wire logic [3:0]   unit_switch,   // configured unit number
   input  wire dccp_tagbus_s tb,            // tags and bus
   input  wire logic         cable_ok,      // open-cable detector, high = ok
   input  wire logic         index_raw,     // servo index event
   input  wire logic         sector_raw,    // servo sector event
   input  wire logic         seek_done,     // actuator reached target
   input  wire logic         fault_cause,   // fault condition present
   input  wire logic         wprot_sw,      // write protect switch
   input  wire logic         spun_up,       // spindle at speed
   output var  logic         unit_sel,      // unit selected
   output var  dccp_status_s stat,          // gated status lines
   output var  logic         write_en,      // write driver enable
   output var  logic         read_en,       // read data enable
   output var  logic         sync_start,    // preamble sync start pulse
   output var  logic [10:0]  seek_cyl,      // target cylinder to actuator
   output var  logic [3:0]   head_sel,      // selected head
   output var  logic         seek_go,       // seek start pulse
   input  wire logic [31:0]  s_axi_awaddr,  // axi write address
   input  wire logic         s_axi_awvalid, // axi
   output var  logic         s_axi_awready, // axi
   input  wire logic [31:0]  s_axi_wdata,   // axi write data
   input  wire logic [3:0]   s_axi_wstrb,   // axi byte enables
   input  wire logic         s_axi_wvalid,  // axi
   output var  logic         s_axi_wready,  // axi
   output var  logic [1:0]   s_axi_bresp,   // axi
   output var  logic         s_axi_bvalid,  // axi
   input  wire logic         s_axi_bready,  // axi
   input  wire logic [31:0]  s_axi_araddr,  // axi read address
   input  wire logic         s_axi_arvalid, // axi
   output var  logic         s_axi_arready, // axi
   output var  logic [31:0]  s_axi_rdata,   // axi read data
   output var  logic [1:0]   s_axi_rresp,   // axi
   output var  logic         s_axi_rvalid,  // axi
   input  wire logic         s_axi_rready   // axi
);
   typedef enum logic [1:0] {SK_IDLE, SK_RUN, SK_TZ} dccp_seek_e;

   typedef struct packed {
      logic         sel;
      dccp_status_s stat;
      logic         we;
      logic         re;
      logic         re_last;
      logic         sync;
      logic [10:0]  cyl;
      logic [3:0]   head;
      logic         go;
      logic         fault;
      logic         seek_err;
      logic         on_cyl;
      dccp_seek_e   sk;
      logic [31:0]  tmr;
      logic         lost;
      logic         aw_got;
      logic         w_got;
      logic [7:0]   aw_a;
      logic [31:0]  w_d;
      logic         w_s;
      logic         bv;
      logic [1:0]   br;
      logic         rv;
      logic [31:0]  rd;
      logic [1:0]   rr;
      logic         ctl_en;
      logic         awr;
      logic         wr;
      logic         arr;
   } dccp_st_s;

   dccp_st_s st, next_st;
   logic       idx_p;
   logic       sec_p;
   logic [19:0] clr_len;
   logic       clr_fall;
   logic [19:0] tz_len;
   logic       tz_fall;
   logic       live;
   logic       one_tag;
   logic       ctl_v;
   logic       fclr_lvl;
   logic       tz_lvl;

   // ==========================================================
   // index and sector pulse shaping
   // ==========================================================
   dccp_pulse #(.WIDTH(IDX_CYC)) u_idx (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .trig     (index_raw),
      .pulse    (idx_p)
   );
   dccp_pulse #(.WIDTH(IDX_CYC)) u_sec (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .trig     (sector_raw),
      .pulse    (sec_p)
   );

   // ==========================================================
   // control pulse width measurement
   // ==========================================================
   dccp_sync u_clr (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .lvl      (fclr_lvl),
      .len      (clr_len),
      .fall     (clr_fall)
   );
   dccp_sync u_tz (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .lvl      (tz_lvl),
      .len      (tz_len),
      .fall     (tz_fall)
   );

   assign live = cable_ok;
   assign one_tag = (32'(tb.tag_cyl) + 32'(tb.tag_head) + 32'(tb.tag_ctl)) == 32'd1;
   assign ctl_v = live && st.sel && one_tag && tb.tag_ctl;
   assign fclr_lvl = ctl_v && tb.bus[B_FCLR];
   assign tz_lvl = ctl_v && tb.bus[B_TZ];

   // ==========================================================
   // next state
   // ==========================================================
   always_comb begin
      next_st = st;
      next_st.go = 1'b0;
      next_st.sync = 1'b0;
      next_st.sel = live && sel_tag && (unit_num == unit_switch);
      next_st.we = ctl_v && tb.bus[B_WG] && !st.fault && !wprot_sw && st.ctl_en;
      next_st.re = ctl_v && tb.bus[B_RG] && st.ctl_en;
      next_st.re_last = next_st.re;
      next_st.sync = next_st.re && !st.re_last;
      // remaining control bits are not decoded
      if (live && st.sel && one_tag && tb.tag_cyl && st.ctl_en) begin
         next_st.cyl = tb.bus;
         next_st.go = 1'b1;
         next_st.on_cyl = 1'b0;
         next_st.sk = SK_RUN;
         next_st.tmr = 32'(SEEK_CYC);
         if (32'(tb.bus) > 32'(MAX_CYL)) next_st.seek_err = 1'b1;
      end
      if (live && st.sel && one_tag && tb.tag_head && st.ctl_en) begin
         next_st.head = tb.bus[HEAD_W-1:0];
      end
      // fault clear after a long enough pulse
      if (fault_cause) begin
         next_st.fault = 1'b1;
      end else if (clr_fall && clr_len >= 20'(CLR_CYC)) begin
         next_st.fault = 1'b0;
      end
      if (tz_fall && tz_len >= 20'(CLR_CYC) && tz_len <= 20'(TZ_MAX_CYC)) begin
         next_st.cyl = '0;
         next_st.go = 1'b1;
         next_st.seek_err = 1'b0;
         next_st.on_cyl = 1'b0;
         next_st.sk = SK_TZ;
         next_st.tmr = st.lost ? 32'(SLOW_CYC) : 32'(SEEK_CYC);
      end
      case (st.sk)
         SK_IDLE: begin
         end
         SK_RUN, SK_TZ: begin
            // a command in this cycle wins over the old seek ending
            if (!next_st.go) begin
               if (st.tmr != 32'h0000_0000) next_st.tmr = st.tmr - 32'h0000_0001;
               if (seek_done || st.tmr == 32'h0000_0001) begin
                  next_st.sk = SK_IDLE;
                  next_st.on_cyl = seek_done && !next_st.seek_err;
                  if (!seek_done) next_st.seek_err = 1'b1;
                  next_st.lost = !seek_done;
               end
            end
         end
         default: next_st.sk = SK_IDLE;
      endcase
      next_st.stat.index = next_st.sel && idx_p;
      next_st.stat.sector = next_st.sel && sec_p;
      next_st.stat.fault = next_st.sel && next_st.fault;
      next_st.stat.seek_err = next_st.sel && next_st.seek_err;
      next_st.stat.on_cyl = next_st.sel && next_st.on_cyl;
      next_st.stat.ready = next_st.sel && spun_up && !next_st.fault;
      next_st.stat.wprot = next_st.sel && wprot_sw;
      next_st.stat.busy = 1'b0;
      // axi write channel
      if (s_axi_awvalid && st.awr) begin
         next_st.aw_got = 1'b1;
         next_st.aw_a = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && st.wr) begin
         next_st.w_got = 1'b1;
         next_st.w_d = s_axi_wdata;
         next_st.w_s = s_axi_wstrb[0];
      end
      if (st.aw_got && st.w_got && !st.bv) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bv = 1'b1;
         next_st.br = RESP_OK;
         if (st.aw_a == A_CTRL) begin
            if (st.w_s) next_st.ctl_en = st.w_d[0];
         end else if (st.aw_a != A_STAT && st.aw_a != A_CYL && st.aw_a != A_HEAD) begin
            next_st.br = RESP_ERR;
         end
      end
      if (st.bv && s_axi_bready) next_st.bv = 1'b0;
      // axi read channel
      if (s_axi_arvalid && st.arr) begin
         next_st.rv = 1'b1;
         next_st.rr = RESP_OK;
         case (s_axi_araddr[7:0])
            A_CTRL: next_st.rd = {31'h0000_0000, st.ctl_en};
            A_STAT: next_st.rd = {20'h0_0000, st.sk, st.lost, st.sel, st.stat};
            A_CYL: next_st.rd = {21'h00_0000, st.cyl};
            A_HEAD: next_st.rd = {28'h000_0000, st.head};
            default: begin
               next_st.rd = '0;
               next_st.rr = RESP_ERR;
            end
         endcase
      end
      if (st.rv && s_axi_rready) next_st.rv = 1'b0;
      // ready flags kept in flops so the bus outputs come from registers
      next_st.awr = !next_st.aw_got;
      next_st.wr = !next_st.w_got;
      next_st.arr = !next_st.rv;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
         st.ctl_en <= CTRL_RST[0];
         st.sk <= SK_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign unit_sel = st.sel;
   assign stat = st.stat;
   assign write_en = st.we;
   assign read_en = st.re;
   assign sync_start = st.sync;
   assign seek_cyl = st.cyl;
   assign head_sel = st.head;
   assign seek_go = st.go;
   assign s_axi_awready = st.awr;
   assign s_axi_wready = st.wr;
   assign s_axi_bvalid = st.bv;
   assign s_axi_bresp = st.br;
   assign s_axi_arready = st.arr;
   assign s_axi_rvalid = st.rv;
   assign s_axi_rdata = st.rd;
   assign s_axi_rresp = st.rr;

   // ==========================================================
   // checks
   // ==========================================================
   property p_sel;
      @(posedge core_clk) disable iff (sys_rst)
      (cable_ok && sel_tag && unit_num == unit_switch) |=> unit_sel;
   endproperty
   a_sel: assert property (p_sel) else $error("select late");

   property p_open;
      @(posedge core_clk) disable iff (sys_rst)
      !cable_ok |=> !unit_sel && !write_en && !read_en;
   endproperty
   a_open: assert property (p_open) else $error("open cable not disabling");

   property p_gate;
      @(posedge core_clk) disable iff (sys_rst)
      !unit_sel |-> stat == '0;
   endproperty
   a_gate: assert property (p_gate) else $error("status not gated");

   property p_wg;
      @(posedge core_clk) disable iff (sys_rst)
      write_en |-> $past(tb.tag_ctl) && $past(tb.bus[B_WG]);
   endproperty
   a_wg: assert property (p_wg) else $error("write without gate");

   property p_rg;
      @(posedge core_clk) disable iff (sys_rst)
      $rose(read_en) |-> sync_start ##1 !sync_start;
   endproperty
   a_rg: assert property (p_rg) else $error("no sync on read edge");

   property p_onc;
      @(posedge core_clk) disable iff (sys_rst)
      seek_go |-> !st.on_cyl;
   endproperty
   a_onc: assert property (p_onc) else $error("on cyl kept in seek");

   property p_tz;
      @(posedge core_clk) disable iff (sys_rst)
      (tz_fall && tz_len >= 20'(CLR_CYC) && tz_len <= 20'(TZ_MAX_CYC))
         |=> seek_go && seek_cyl == '0 && !st.seek_err;
   endproperty
   a_tz: assert property (p_tz) else $error("track zero not started");

   property p_head;
      @(posedge core_clk) disable iff (sys_rst)
      (ctl_v == 1'b0 && live && st.sel && one_tag && tb.tag_head && st.ctl_en)
         |=> head_sel == $past(tb.bus[3:0]);
   endproperty
   a_head: assert property (p_head) else $error("head not loaded");

   property p_fclr;
      @(posedge core_clk) disable iff (sys_rst)
      (clr_fall && clr_len < 20'(CLR_CYC) && st.fault) |=> st.fault;
   endproperty
   a_fclr: assert property (p_fclr) else $error("short clear took effect");
endmodule
`default_nettype wire

// ===== verification/dccp_host_model.sv
// host controller model driving the control cable
`timescale 1ns/1ps
`default_nettype none
module dccp_host_model
   import dccp_pkg::*;
#(
   parameter int GAP_CYC = 100 // 2 us spacing between commands
) (
   input  wire logic         core_clk, // clock
   output var  logic         sel_tag,  // unit selection strobe
   output var  logic [3:0]   unit_num, // unit number lines
   output var  dccp_tagbus_s tb        // tags and bus
);
   initial begin
      sel_tag = 1'b0;
      unit_num = 4'h0;
      tb = '0;
   end
   task automatic select(input logic [3:0] u, input logic on);
      @(posedge core_clk);
      unit_num <= u;
      sel_tag <= on;
   endtask
   task automatic op_on(input logic [2:0] tags, input logic [10:0] bits);
      @(posedge core_clk);
      tb <= {tags, bits};
   endtask
   task automatic op_off();
      @(posedge core_clk);
      tb <= {3'h0, ~tb.bus};
      repeat (GAP_CYC) @(posedge core_clk);
   endtask
   // write gate raised only after a hold-off of hold_off cycles from the call
   task automatic write_gate(input int hold_off);
      repeat (hold_off) @(posedge core_clk);
      op_on(3'h1, 11'h001);
   endtask
endmodule
`default_nettype wire

// ===== verification/test_disk_control_cable_port.sv
// self-checking testbench for the control cable port
`timescale 1ns/1ps
`default_nettype none
module test_disk_control_cable_port
   import dccp_pkg::*;
;
   localparam logic [3:0] MY_UNIT = 4'h6;
   logic         core_clk, sys_rst, cable_ok, index_raw, sector_raw;
   logic         seek_done, fault_cause, wprot_sw, sel_tag;
   logic [3:0]   unit_num;
   dccp_tagbus_s tb;
   dccp_status_s stat;
   logic         unit_sel, write_en, read_en, sync_start, seek_go;
   logic [10:0]  seek_cyl;
   logic [3:0]   head_sel;
   logic [31:0]  awaddr, wdata, araddr, rdata;
   logic [3:0]   wstrb;
   logic         awvalid, wvalid, bready, arvalid, rready;
   logic         awready, wready, bvalid, arready, rvalid;
   logic [1:0]   bresp, rresp;
   int           n_fail, n_compared, n_sync, n_go;

   dccp_host_model host_u (.core_clk(core_clk), .sel_tag(sel_tag), .unit_num(unit_num), .tb(tb));
   dccp_top #(.SEEK_CYC(400), .SLOW_CYC(2000)) dut_u (
      .core_clk(core_clk), .sys_rst(sys_rst), .sel_tag(sel_tag), .unit_num(unit_num),
      .unit_switch(MY_UNIT), .tb(tb), .cable_ok(cable_ok), .index_raw(index_raw),
      .sector_raw(sector_raw), .seek_done(seek_done), .fault_cause(fault_cause),
      .wprot_sw(wprot_sw), .spun_up(1'b1), .unit_sel(unit_sel), .stat(stat),
      .write_en(write_en), .read_en(read_en), .sync_start(sync_start),
      .seek_cyl(seek_cyl), .head_sel(head_sel), .seek_go(seek_go),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      n_sync <= n_sync + int'(sync_start === 1'b1);
      n_go <= n_go + int'(seek_go === 1'b1);
   end

   task automatic stop_test();
      if (n_fail == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            r = bresp;
            done = 1;
         end
      end
   endtask
   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            d = rdata;
            r = rresp;
            done = 1;
         end
      end
   endtask
   task automatic pulse_bit(input int b, input int n);
      host_u.op_on(3'h1, 11'(1 << b));
      repeat (n) @(posedge core_clk);
      host_u.op_off();
   endtask
   task automatic done_pulse();
      @(posedge core_clk);
      seek_done <= 1'b1;
      @(posedge core_clk);
      seek_done <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic t_select();
      host_u.select(4'h9, 1'b1);
      repeat (40) @(posedge core_clk);
      chk("unit_sel_other", unit_sel, 0);
      chk("stat_gated", stat, 8'h00);
      host_u.select(MY_UNIT, 1'b1);
      for (int k = 0; k < SEL_CYC && unit_sel !== 1'b1; k++) @(posedge core_clk);
      chk("unit_sel", unit_sel, 1);
      chk("busy", stat.busy, 0);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0]  r;
      host_u.op_on(3'h1, 11'h001);
      repeat (4) @(posedge core_clk);
      chk("wr_disabled", write_en, 0);
      host_u.op_off();
      axi_rd(32'(A_CTRL), d, r);
      chk("ctrl_rst", d, CTRL_RST);
      axi_rd(32'h0000_0040, d, r);
      chk("unmapped_rresp", r, RESP_ERR);
      chk("unmapped_rdata", d, 0);
      axi_wr(32'h0000_0040, 32'h0000_0001, r);
      chk("unmapped_bresp", r, RESP_ERR);
      axi_wr(32'(A_CTRL), 32'h0000_0001, r);
      chk("ctrl_bresp", r, RESP_OK);
      axi_rd(32'(A_CTRL), d, r);
      chk("ctrl", d, 32'h0000_0001);
      axi_rd(32'(A_STAT), d, r);
      chk("stat_sel", d[8], 1);
   endtask
   task automatic t_seek();
      int g0;
      host_u.op_on(3'h2, 11'h7F5);
      repeat (4) @(posedge core_clk);
      chk("head_sel", head_sel, 4'h5);
      host_u.op_off();
      g0 = n_go;
      host_u.op_on(3'h4, 11'h42B);
      repeat (4) @(posedge core_clk);
      chk("seek_cyl", seek_cyl, 11'h42B);
      chk("seek_go", n_go > g0, 1);
      chk("on_cyl_drop", stat.on_cyl, 0);
      host_u.op_off();
      done_pulse();
      chk("on_cyl_back", stat.on_cyl, 1);
      chk("seek_err_ok", stat.seek_err, 0);
   endtask
   task automatic t_ctl();
      int s0;
      for (int b = 0; b < 11; b++) begin
         if (b != B_FCLR && b != B_TZ) begin
            s0 = n_sync;
            host_u.op_on(3'h1, 11'(1 << b));
            repeat (4) @(posedge core_clk);
            chk("write_en", write_en, b == B_WG);
            chk("read_en", read_en, b == B_RG);
            chk("sync_start", n_sync - s0, b == B_RG);
            chk("on_cyl_kept", stat.on_cyl, 1);
            host_u.op_off();
         end
      end
      host_u.op_on(3'h3, 11'h001);
      repeat (4) @(posedge core_clk);
      chk("two_tags", write_en, 0);
      host_u.op_off();
   endtask
   task automatic t_err();
      host_u.op_on(3'h4, 11'h7FF);
      repeat (4) @(posedge core_clk);
      host_u.op_off();
      chk("seek_err_range", stat.seek_err, 1);
      // let the out-of-range seek time out so head position counts as lost
      repeat (400) @(posedge core_clk);
      pulse_bit(B_TZ, 15);
      chk("tz_cyl", seek_cyl, 11'h000);
      chk("tz_clear", stat.seek_err, 0);
      repeat (800) @(posedge core_clk);
      chk("slow_tz_wait", stat.seek_err, 0);
      repeat (1200) @(posedge core_clk);
      chk("slow_tz_end", stat.seek_err, 1);
      pulse_bit(B_TZ, 15);
      done_pulse();
      chk("tz_done_err", stat.seek_err, 0);
      chk("tz_done_cyl", stat.on_cyl, 1);
   endtask
   task automatic t_fault();
      @(posedge core_clk);
      fault_cause <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("fault_set", stat.fault, 1);
      chk("ready_fault", stat.ready, 0);
      pulse_bit(B_FCLR, 15);
      chk("fault_cause_on", stat.fault, 1);
      @(posedge core_clk);
      fault_cause <= 1'b0;
      pulse_bit(B_FCLR, 6);
      chk("fault_short", stat.fault, 1);
      pulse_bit(B_FCLR, 15);
      chk("fault_clear", stat.fault, 0);
      chk("ready", stat.ready, 1);
   endtask
   task automatic t_index();
      int n;
      for (int w = 0; w < 2; w++) begin
         n = 0;
         @(posedge core_clk);
         index_raw <= (w == 0);
         sector_raw <= (w == 1);
         for (int k = 0; k < 200; k++) begin
            @(posedge core_clk);
            index_raw <= 1'b0;
            sector_raw <= 1'b0;
            if ((w == 0 ? stat.index : stat.sector) === 1'b1) n++;
         end
         chk("pulse_width", n, IDX_CYC);
      end
      host_u.write_gate(200);
      repeat (4) @(posedge core_clk);
      chk("wr_after_sector", write_en, 1);
      host_u.op_off();
      wprot_sw <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("wprot", stat.wprot, 1);
      wprot_sw <= 1'b0;
   endtask
   task automatic t_cable();
      host_u.select(MY_UNIT, 1'b0);
      repeat (3) @(posedge core_clk);
      chk("deselect", unit_sel, 0);
      chk("stat_off", stat, 8'h00);
      host_u.op_on(3'h1, 11'h001);
      repeat (4) @(posedge core_clk);
      chk("wr_unselected", write_en, 0);
      host_u.op_off();
      host_u.select(MY_UNIT, 1'b1);
      repeat (3) @(posedge core_clk);
      chk("reselect", unit_sel, 1);
      cable_ok <= 1'b0;
      host_u.op_on(3'h1, 11'h001);
      repeat (4) @(posedge core_clk);
      chk("cable_sel", unit_sel, 0);
      chk("cable_wr", write_en, 0);
      host_u.op_off();
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      stop_test();
   end
   initial begin
      {sys_rst, cable_ok} = 2'h3;
      {index_raw, sector_raw, seek_done, fault_cause, wprot_sw} = 5'h00;
      {awaddr, wdata, araddr} = '0;
      wstrb = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {n_fail, n_compared, n_sync, n_go} = '0;
      repeat (10) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_select();
      t_regs();
      t_seek();
      t_ctl();
      t_err();
      t_fault();
      t_index();
      t_cable();
      stop_test();
   end
endmodule
`default_nettype wire
